// ---- src/dis_top.sv ----
/*
  device interrupt source flags: latches endpoint, bus and dma events,
  tracks bus sleep, answers the flag read command with two 16-bit words.
  assumes command and read strobes are one-cycle pulses synchronous to
  clk_sys, and that event inputs are one-cycle pulses.
*/
`default_nettype none

`include "dis_defs.svh"

module dis_top
  import dis_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `DIS_TICK_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        cmd_stb,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        rd_stb,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  input  wire logic [13:0] ep_evt,
  input  wire logic        ctl_in_evt,
  input  wire logic        ctl_out_evt,
  input  wire logic        short_done_evt,
  input  wire logic        dma_done_evt,
  input  wire logic        sof_evt,
  input  wire logic        resume_evt,
  input  wire logic        bus_rst_evt,
  input  wire logic [31:0] interrupt_enable_mask,
  output logic             irq
);

  // --------------------------------------------------------------------
  // frame timing
  // --------------------------------------------------------------------
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  logic [TW-1:0] tick_cnt_q;
  logic          pseudo_tick;
  logic [1:0]    miss_q;
  logic          sleep_q;
  logic          sleep_entry;

  // a real marker restarts the period so pseudo ticks only fill gaps
  assign pseudo_tick = (tick_cnt_q == TW'(TICK_CYCLES - 1)) && !sof_evt;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= '0;
    end else if (sof_evt || pseudo_tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      miss_q <= 2'h0;
    end else if (sof_evt || resume_evt || bus_rst_evt) begin
      miss_q <= 2'h0;
    end else if (pseudo_tick && miss_q != `DIS_MISS_LIMIT) begin
      miss_q <= miss_q + 2'h1;
    end
  end

  assign sleep_entry = pseudo_tick && !sleep_q &&
                       miss_q == `DIS_MISS_LIMIT - 2'h1 &&
                       !resume_evt && !bus_rst_evt;

  // a frame marker, resume or bus reset wakes the bus again; endpoint and dma events do not
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sleep_q <= 1'b0;
    end else if (sof_evt || resume_evt || bus_rst_evt) begin
      sleep_q <= 1'b0;
    end else if (sleep_entry) begin
      sleep_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // event flags
  // --------------------------------------------------------------------
  logic [31:0] set_vec;
  logic [31:0] flags_q;
  logic [31:0] snap_q;
  logic [31:0] view;
  logic        clr_now;

  genvar g;
  generate
    for (g = 0; g < `DIS_EP_N; g++) begin : g_ep
      assign set_vec[`DIS_EP_LSB + g] = ep_evt[g];
    end
  endgenerate

  assign set_vec[31:24] = 8'h00;
  assign set_vec[`DIS_BIT_CTL_IN]    = ctl_in_evt;
  assign set_vec[`DIS_BIT_CTL_OUT]   = ctl_out_evt;
  assign set_vec[`DIS_BIT_SLEEP]     = 1'b0;
  assign set_vec[`DIS_BIT_SHORT_DONE] = short_done_evt;
  assign set_vec[`DIS_BIT_PSEUDO]     = pseudo_tick;
  assign set_vec[`DIS_BIT_SOF]        = sof_evt;
  assign set_vec[`DIS_BIT_DMA_DONE]   = dma_done_evt;
  assign set_vec[`DIS_BIT_SLEEP_IN]  = sleep_entry;
  assign set_vec[`DIS_BIT_RESUME]    = resume_evt;
  assign set_vec[`DIS_BIT_BUS_RST]   = bus_rst_evt;

  // only flags the processor has seen are cleared; a set wins the race
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= `DIS_FLAGS_RESET;
    end else if (clr_now) begin
      flags_q <= (flags_q & ~snap_q) | set_vec;
    end else begin
      flags_q <= flags_q | set_vec;
    end
  end

  // live bus state sits beside the latched flags
  always_comb begin
    view = flags_q;
    view[`DIS_BIT_SLEEP] = sleep_q;
  end

  // --------------------------------------------------------------------
  // command read
  // --------------------------------------------------------------------
  dis_rd_t rd_q;

  assign clr_now = rd_stb && rd_q == DIS_HIGH && !cmd_stb;

  // any other command abandons a half read; flags then stay set
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= DIS_IDLE;
    end else if (cmd_stb) begin
      rd_q <= (cmd_code == `DIS_CMD_RD_FLAGS) ? DIS_LOW : DIS_IDLE;
    end else if (rd_stb) begin
      unique case (rd_q)
        DIS_IDLE: rd_q <= DIS_IDLE;
        DIS_LOW:  rd_q <= DIS_HIGH;
        DIS_HIGH: rd_q <= DIS_IDLE;
      endcase
    end
  end

  // the snapshot keeps both words coherent across the two reads
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      snap_q <= `DIS_FLAGS_RESET;
    end else if (cmd_stb && cmd_code == `DIS_CMD_RD_FLAGS) begin
      snap_q <= view;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_stb && !cmd_stb;
      if (rd_stb && !cmd_stb) begin
        unique case (rd_q)
          DIS_LOW:  rd_data <= snap_q[15:0];
          DIS_HIGH: rd_data <= snap_q[31:16];
          DIS_IDLE: rd_data <= 16'h0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // interrupt output
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_q & interrupt_enable_mask);
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_open;
    cmd_stb && cmd_code == `DIS_CMD_RD_FLAGS;
  endsequence

  sequence s_first;
    rd_stb && !cmd_stb && rd_q == DIS_LOW;
  endsequence

  property p_first_word;
    s_open ##1 s_first |=> rd_valid && rd_data == $past(snap_q[15:0]);
  endproperty
  a_first_word: assert property (p_first_word)
    else $error("first word is not low half of snapshot");

  property p_second_word;
    rd_stb && !cmd_stb && rd_q == DIS_HIGH
      |=> rd_valid && rd_data == $past(snap_q[31:16]);
  endproperty
  a_second_word: assert property (p_second_word)
    else $error("second word is not high half of snapshot");

  property p_ep_set;
    ep_evt[0] |=> flags_q[`DIS_EP_LSB];
  endproperty
  a_ep_set: assert property (p_ep_set)
    else $error("endpoint one event not latched");

  property p_ctl_in;
    ctl_in_evt |=> flags_q[`DIS_BIT_CTL_IN];
  endproperty
  a_ctl_in: assert property (p_ctl_in)
    else $error("control in event not latched");

  property p_ctl_out;
    ctl_out_evt |=> flags_q[`DIS_BIT_CTL_OUT];
  endproperty
  a_ctl_out: assert property (p_ctl_out)
    else $error("control out event not latched");

  property p_state_live;
    s_open |=> snap_q[`DIS_BIT_SLEEP] == $past(sleep_q);
  endproperty
  a_state_live: assert property (p_state_live)
    else $error("bus state bit does not follow sleep state");

  property p_wake;
    sof_evt |=> !sleep_q;
  endproperty
  a_wake: assert property (p_wake)
    else $error("frame marker did not wake bus");

  property p_sleep_flag;
    !sleep_q ##1 sleep_q |-> flags_q[`DIS_BIT_SLEEP_IN];
  endproperty
  a_sleep_flag: assert property (p_sleep_flag)
    else $error("sleep entry not flagged");

  property p_tick_gap;
    pseudo_tick |=> !pseudo_tick [*2];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("pseudo frame ticks too close");

  property p_sticky;
    flags_q[`DIS_BIT_BUS_RST] && !clr_now |=> flags_q[`DIS_BIT_BUS_RST];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("bus reset flag lost without full read");

  property p_set_wins;
    clr_now && resume_evt |=> flags_q[`DIS_BIT_RESUME];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("resume lost in clear cycle");

  property p_irq;
    ##1 irq == |($past(flags_q) & $past(interrupt_enable_mask));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output does not match enabled flags");

  property p_sleep_kept;
    clr_now |=> sleep_q == $past(sleep_q) || $past(sof_evt)
            || $past(resume_evt) || $past(bus_rst_evt) || $past(sleep_entry);
  endproperty
  a_sleep_kept: assert property (p_sleep_kept)
    else $error("full read altered bus state");

  property p_refused;
    rd_stb && !cmd_stb && rd_q == DIS_IDLE
      |=> rd_valid && rd_data == 16'h0000;
  endproperty
  a_refused: assert property (p_refused)
    else $error("read without open command returned data");

  property p_pseudo_flag;
    pseudo_tick |=> flags_q[`DIS_BIT_PSEUDO];
  endproperty
  a_pseudo_flag: assert property (p_pseudo_flag)
    else $error("pseudo frame tick not latched");

endmodule : dis_top

`default_nettype wire

// ---- src/dis_defs.svh ----
/*
  constants of the device interrupt source block: command code, field
  positions, timing counts.
  assumes inclusion by bare name from the block's design files.
*/
`ifndef DIS_DEFS_SVH
`define DIS_DEFS_SVH

// ----------------------------------------------------------------------
// command and layout
// ----------------------------------------------------------------------
`define DIS_CMD_RD_FLAGS   8'hc0
`define DIS_FLAGS_W        32
`define DIS_FLAGS_RESET    32'h0000_0000
`define DIS_EP_LSB         10
`define DIS_EP_N           14
`define DIS_BIT_CTL_IN     9
`define DIS_BIT_CTL_OUT    8
`define DIS_BIT_SLEEP      7
`define DIS_BIT_SHORT_DONE 6
`define DIS_BIT_PSEUDO     5
`define DIS_BIT_SOF        4
`define DIS_BIT_DMA_DONE   3
`define DIS_BIT_SLEEP_IN   2
`define DIS_BIT_RESUME     1
`define DIS_BIT_BUS_RST    0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DIS_CLK_KHZ        40000
`define DIS_TICK_US        1000
`define DIS_TICK_CYC       ((`DIS_TICK_US * `DIS_CLK_KHZ) / 1000)
`define DIS_MISS_LIMIT     2'h3

`endif

// ---- src/dis_pkg.sv ----
/*
  types of the device interrupt source block.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package dis_pkg;
  typedef enum logic [1:0] {
    DIS_IDLE,
    DIS_LOW,
    DIS_HIGH
  } dis_rd_t;
endpackage : dis_pkg

`default_nettype wire

// ---- tb/dis_cpu_model.sv ----
/*
  processor model: sends flag read commands and word reads to dis_top.
  assumes one clock and the strobe timing of dis_top.
*/
`default_nettype none

module dis_cpu_model (
  input  wire logic        clk_sys,
  output var  logic        cmd_stb,
  output var  logic [7:0]  cmd_code,
  output var  logic        rd_stb,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------
  // command and read sequencing
  // --------------------------------------------------------------
  logic busy;
  initial begin
    cmd_stb  = 1'b0;
    cmd_code = 8'h00;
    rd_stb   = 1'b0;
    busy     = 1'b0;
  end
  // idle code toggles each cycle, so a stale code such as 8'hc0 returns every second cycle but is never held steady
  always @(posedge clk_sys) if (!busy) cmd_code <= ~cmd_code;

  task automatic xfer(input logic c, input logic [7:0] code, input int n,
                      output logic [31:0] v, output logic ok);
    int k;
    v    = '0;
    ok   = 1'b1;
    busy = 1'b1;
    if (c) begin
      @(posedge clk_sys);
      cmd_stb  <= 1'b1;
      cmd_code <= code;
    end
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      cmd_stb <= 1'b0;
      rd_stb  <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
      end while (rd_valid !== 1'b1 && k < 4);
      if (rd_valid !== 1'b1) ok = 1'b0;
      v[16*i +: 16] = rd_data;
    end
    @(posedge clk_sys);
    cmd_stb <= 1'b0;
    busy = 1'b0;
  endtask : xfer
endmodule : dis_cpu_model

`default_nettype wire

// ---- tb/dis_top_bench.sv ----
/*
  self-checking bench of dis_top: event table, refusals, sleep, reset.
  assumes dis_cpu_model as the processor on the command port.
*/
`default_nettype none

module dis_top_bench
  import dis_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------
  // stimulus and checks
  // --------------------------------------------------------------
  // short tick period keeps the sleep walk to about a thousand cycles
  localparam int P = 300;
  typedef struct packed {
    logic [20:0] ev;
    logic [31:0] exp;
  } dis_row_t;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic [20:0] ev      = '0;
  logic [31:0] mask    = '0;
  logic        cmd_stb, rd_stb, rd_valid, irq, ok;
  logic [7:0]  cmd_code;
  logic [15:0] rd_data;
  logic [31:0] v;
  int          num_errors = 0;
  int          checked    = 0;
  dis_row_t    rows [11] = '{
    '{21'h000080, 32'h0000_0400}, '{21'h100000, 32'h0080_0000},
    '{21'h002000, 32'h0001_0000}, '{21'h1fff80, 32'h00ff_fc00},
    '{21'h000040, 32'h0000_0200}, '{21'h000020, 32'h0000_0100},
    '{21'h000010, 32'h0000_0040}, '{21'h000008, 32'h0000_0008},
    '{21'h000004, 32'h0000_0010}, '{21'h000002, 32'h0000_0002},
    '{21'h000001, 32'h0000_0001}};

  always #12.5 clk_sys = ~clk_sys;

  dis_top #(.TICK_CYCLES(P)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .cmd_stb(cmd_stb),
    .cmd_code(cmd_code), .rd_stb(rd_stb), .rd_data(rd_data),
    .rd_valid(rd_valid), .ep_evt(ev[20:7]), .ctl_in_evt(ev[6]),
    .ctl_out_evt(ev[5]), .short_done_evt(ev[4]), .dma_done_evt(ev[3]),
    .sof_evt(ev[2]), .resume_evt(ev[1]), .bus_rst_evt(ev[0]),
    .interrupt_enable_mask(mask), .irq(irq));
  dis_cpu_model cpu (
    .clk_sys(clk_sys), .cmd_stb(cmd_stb), .cmd_code(cmd_code),
    .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid));

  task automatic test_done;
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    #2;
    checked++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic pulse(input logic [20:0] e, input logic [31:0] m);
    @(posedge clk_sys);
    ev   <= e;
    mask <= m;
    @(posedge clk_sys);
    ev <= '0;
  endtask : pulse

  task automatic xf(input logic c, input logic [7:0] code, input int n);
    cpu.xfer(c, code, n, v, ok);
    if (ok !== 1'b1) begin
      $display("[ERR] rd_valid exp 1 got %b", ok);
      num_errors++;
      test_done();
    end
  endtask : xf

  task automatic rd(input logic [31:0] e);
    xf(1'b1, 8'hc0, 2);
    chk("flags", e, v);
  endtask : rd

  initial begin
    cyc(9);
    chk("rst_out", 32'h0, {rd_data, 14'h0, rd_valid, irq});
    @(posedge clk_sys);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      pulse(rows[i].ev, ~rows[i].exp);
      cyc(2);
      chk("irq_off", 32'h0, {31'h0, irq});
      pulse('0, rows[i].exp);
      cyc(2);
      chk("irq_on", 32'h1, {31'h0, irq});
      rd(rows[i].exp);
    end
    pulse(21'h40, '0);
    xf(1'b0, 8'h00, 1);
    chk("stray", 32'h0, v);
    xf(1'b1, 8'hc0, 1);
    chk("half", 32'h200, v);
    xf(1'b1, 8'hb4, 0);
    rd(32'h200);
    pulse(21'h04, '0);
    rd(32'h10);
    cyc(P - 30);
    rd(32'h0);
    cyc(30);
    rd(32'h20);
    cyc(2 * P);
    rd(32'ha4);
    rd(32'h80);
    pulse(21'h02, '0);
    // a resume landing on the clearing read must survive it
    fork
      rd(32'h02);
      begin
        cyc(4);
        pulse(21'h02, '0);
      end
    join
    rd(32'h02);
    pulse(21'h01, '1);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    cyc(3);
    chk("rst_out", 32'h0, {rd_data, 14'h0, rd_valid, irq});
    @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(32'h0);
    test_done();
  end
endmodule : dis_top_bench

`default_nettype wire
